//--- design/cip_central_interrupt_unit.sv
// central interrupt unit: 32 channels prioritized onto fast and normal lines
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cip_central_interrupt_unit
  import cip_pkg::*;
#(
  parameter int CHANNELS = 32
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                brownoutEvent,
  input  wire logic                externalPinEvent,
  input  wire logic                watchdogExpiredEvent,
  input  wire logic                watchdogHalfwayEvent,
  input  wire logic                serialErrorEvent,
  input  wire logic                serial0ReceiveEvent,
  input  wire logic                serial0TransmitEvent,
  input  wire logic                serial1ReceiveEvent,
  input  wire logic                serial1TransmitEvent,
  input  wire logic                pmbusEvent,
  input  wire logic                comparatorSerialSharedEvent,
  input  wire logic                frontEndZeroEvent,
  input  wire logic                conversionDoneEvent,
  input  wire logic                faultMuxEvent,
  input  wire logic [CHANNELS-1:0] otherRequest,
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [31:0]         regRdata,
  output logic                     fastInterruptRequest,
  output logic                     normalInterruptRequest,
  output logic      [5:0]          fastVectorIndex,
  output logic      [5:0]          normalVectorIndex,
  output logic                     irqOut
);

  import cip_pkg::*;

  // bus gathered for decoding
  cip_bus_s bus;
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWrite, rd: regRead};

  // register write hit test
  function automatic logic wrHit(input cip_bus_s b, input logic [7:0] ofs);
    wrHit = b.wr && (b.addr == ofs);
  endfunction

  // source assembly, named sources override generic inputs
  logic [CHANNELS-1:0] source;
  always_comb begin
    source = otherRequest;
    source[CIP_CH_BROWNOUT]       = brownoutEvent;
    source[CIP_CH_EXT_PIN]        = externalPinEvent;
    source[CIP_CH_WD_EXPIRED]     = watchdogExpiredEvent;
    source[CIP_CH_WD_HALFWAY]     = watchdogHalfwayEvent;
    source[CIP_CH_SERIAL_ERR]     = serialErrorEvent;
    source[CIP_CH_SERIAL0_RX]     = serial0ReceiveEvent;
    source[CIP_CH_SERIAL0_TX]     = serial0TransmitEvent;
    source[CIP_CH_SERIAL1_RX]     = serial1ReceiveEvent;
    source[CIP_CH_SERIAL1_TX]     = serial1TransmitEvent;
    source[CIP_CH_PMBUS]          = pmbusEvent;
    source[CIP_CH_CMP_SERIAL]     = comparatorSerialSharedEvent;
    source[CIP_CH_FRONT_END_ZERO] = frontEndZeroEvent;
    source[CIP_CH_CONV_DONE]      = conversionDoneEvent;
    source[CIP_CH_FAULT_MUX]      = faultMuxEvent;
  end

  // configuration registers
  logic [CHANNELS-1:0] enable_reg;
  logic [CHANNELS-1:0] enable_next;
  logic [CHANNELS-1:0] fastSel_reg;
  logic [CHANNELS-1:0] fastSel_next;
  logic [1:0]          irqMask_reg;
  logic [1:0]          irqMask_next;
  logic [CHANNELS-1:0] clearMask;

  // firmware writes; clearing is write-one to pending
  always_comb begin
    enable_next  = enable_reg;
    fastSel_next = fastSel_reg;
    irqMask_next = irqMask_reg;
    clearMask    = '0;
    if (wrHit(bus, CIP_OFS_ENABLE)) begin
      enable_next = bus.wdata[CHANNELS-1:0];
    end
    if (wrHit(bus, CIP_OFS_FASTSEL)) begin
      fastSel_next = bus.wdata[CHANNELS-1:0];
    end
    if (wrHit(bus, CIP_OFS_IRQMASK)) begin
      irqMask_next = bus.wdata[1:0];
    end
    if (wrHit(bus, CIP_OFS_PENDING)) begin
      clearMask = bus.wdata[CHANNELS-1:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_reg  <= CIP_RST_ENABLE[CHANNELS-1:0];
      fastSel_reg <= CIP_RST_FASTSEL[CHANNELS-1:0];
      irqMask_reg <= CIP_RST_IRQMASK;
    end else begin
      enable_reg  <= enable_next;
      fastSel_reg <= fastSel_next;
      irqMask_reg <= irqMask_next;
    end
  end

  // sticky pending flags
  logic [CHANNELS-1:0] pending;
  cip_sticky_flags #(.WIDTH(CHANNELS)) u_flags (
    .mclk      (mclk),
    .reset     (reset),
    .source    (source),
    .clearMask (clearMask),
    .pending   (pending)
  );

  // split unmasked pending onto the two lines
  logic [CHANNELS-1:0] fastReq;
  logic [CHANNELS-1:0] normReq;
  always_comb begin
    fastReq = pending & enable_reg & fastSel_reg;
    normReq = pending & enable_reg & ~fastSel_reg;
  end

  cip_winner_s fastWin;
  cip_winner_s normWin;
  cip_priority_encoder #(.WIDTH(CHANNELS)) u_fastEnc (
    .req    (fastReq),
    .winner (fastWin)
  );
  cip_priority_encoder #(.WIDTH(CHANNELS)) u_normEnc (
    .req    (normReq),
    .winner (normWin)
  );

  // line state: fast outranks normal
  cip_line_e line_reg;
  cip_line_e line_next;
  always_comb begin
    if (fastWin.valid) begin
      line_next = CIP_FAST;
    end else if (normWin.valid) begin
      line_next = CIP_NORM;
    end else begin
      line_next = CIP_IDLE;
    end
  end

  // line state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      line_reg <= CIP_IDLE;
    end else begin
      line_reg <= line_next;
    end
  end

  // registered outputs; the four request and index outputs share one flop group
  logic        fastReq_reg;
  logic        fastReq_next;
  logic        normReq_reg;
  logic        normReq_next;
  logic [5:0]  fastIdx_reg;
  logic [5:0]  fastIdx_next;
  logic [5:0]  normIdx_reg;
  logic [5:0]  normIdx_next;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic        irq_reg;
  logic        irq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // request lines and winning indices
  always_comb begin
    fastReq_next = fastWin.valid;
    normReq_next = normWin.valid;
    fastIdx_next = fastWin.index;
    normIdx_next = normWin.index;
  end

  // request and index flops, indices idle at the none value
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fastReq_reg <= 1'b0;
      normReq_reg <= 1'b0;
      fastIdx_reg <= CIP_IDX_NONE;
      normIdx_reg <= CIP_IDX_NONE;
    end else begin
      fastReq_reg <= fastReq_next;
      normReq_reg <= normReq_next;
      fastIdx_reg <= fastIdx_next;
      normIdx_reg <= normIdx_next;
    end
  end

  // sticky line events, set wins over write-one clear
  always_comb begin
    status_next = status_reg;
    if (wrHit(bus, CIP_OFS_STATUS)) begin
      status_next = status_reg & ~bus.wdata[1:0];
    end
    if (fastWin.valid) begin
      status_next[CIP_ST_FAST] = 1'b1;
    end
    if (normWin.valid) begin
      status_next[CIP_ST_NORM] = 1'b1;
    end
  end

  // status flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // level interrupt follows next status and mask together
  always_comb begin
    irq_next = |(status_next & irqMask_next);
  end

  // interrupt flop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // read mux, answer in the following cycle
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus.rd) begin
      unique case (bus.addr)
        CIP_OFS_PENDING: rdata_next = 32'(pending);
        CIP_OFS_ENABLE:  rdata_next = 32'(enable_reg);
        CIP_OFS_FASTSEL: rdata_next = 32'(fastSel_reg);
        CIP_OFS_FASTIDX: rdata_next = {26'h0, fastIdx_reg};
        CIP_OFS_NORMIDX: rdata_next = {26'h0, normIdx_reg};
        CIP_OFS_STATUS:  rdata_next = {30'h0, status_reg};
        CIP_OFS_IRQMASK: rdata_next = {30'h0, irqMask_reg};
        CIP_OFS_RAW:     rdata_next = 32'(source);
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // read data flop, zero outside the answer slot
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign fastInterruptRequest   = fastReq_reg;
  assign normalInterruptRequest = normReq_reg;
  assign fastVectorIndex        = fastIdx_reg;
  assign normalVectorIndex      = normIdx_reg;
  assign irqOut                 = irq_reg;
  assign regRdata               = rdata_reg;

endmodule
`default_nettype wire

//--- design/cip_pkg.sv
// package: constants and types of the central interrupt prioritizer
package cip_pkg;

  localparam int CIP_CHANNELS = 32;
  localparam int CIP_IDX_W    = 6;

  // channel assignment of the fixed sources
  localparam int CIP_CH_BROWNOUT       = 0;
  localparam int CIP_CH_EXT_PIN        = 1;
  localparam int CIP_CH_WD_EXPIRED     = 2;
  localparam int CIP_CH_WD_HALFWAY     = 3;
  localparam int CIP_CH_SERIAL_ERR     = 4;
  localparam int CIP_CH_SERIAL0_RX     = 5;
  localparam int CIP_CH_SERIAL0_TX     = 6;
  localparam int CIP_CH_SERIAL1_RX     = 7;
  localparam int CIP_CH_SERIAL1_TX     = 8;
  localparam int CIP_CH_PMBUS          = 9;
  localparam int CIP_CH_CMP_SERIAL     = 10;
  localparam int CIP_CH_FRONT_END_ZERO = 11;
  localparam int CIP_CH_CONV_DONE      = 24;
  localparam int CIP_CH_FAULT_MUX      = 25;

  // register offsets (byte addresses)
  localparam logic [7:0] CIP_OFS_PENDING = 8'h00;
  localparam logic [7:0] CIP_OFS_ENABLE  = 8'h04;
  localparam logic [7:0] CIP_OFS_FASTSEL = 8'h08;
  localparam logic [7:0] CIP_OFS_FASTIDX = 8'h0C;
  localparam logic [7:0] CIP_OFS_NORMIDX = 8'h10;
  localparam logic [7:0] CIP_OFS_STATUS  = 8'h14;
  localparam logic [7:0] CIP_OFS_IRQMASK = 8'h18;
  localparam logic [7:0] CIP_OFS_RAW     = 8'h1C;

  // reset values
  localparam logic [31:0] CIP_RST_ENABLE  = 32'h0000_0000;
  localparam logic [31:0] CIP_RST_FASTSEL = 32'h0000_0000;
  localparam logic [1:0]  CIP_RST_IRQMASK = 2'h0;

  // index reported when nothing is pending on a line
  localparam logic [5:0] CIP_IDX_NONE = 6'h3F;

  // status bit positions
  localparam int CIP_ST_FAST = 0;
  localparam int CIP_ST_NORM = 1;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cip_bus_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] index;
  } cip_winner_s;

  // one-hot processor-facing request state
  typedef enum logic [2:0] {
    CIP_IDLE = 3'b001,
    CIP_FAST = 3'b010,
    CIP_NORM = 3'b100
  } cip_line_e;

endpackage

//--- design/cip_priority_encoder.sv
// highest-numbered set bit finder
`timescale 1ns/1ps
`default_nettype none
module cip_priority_encoder
  import cip_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] req,
  output cip_pkg::cip_winner_s  winner
);

  import cip_pkg::*;

  // scan upward so the highest channel wins
  always_comb begin
    winner.valid = 1'b0;
    winner.index = CIP_IDX_NONE;
    for (int i = 0; i < WIDTH; i++) begin
      if (req[i]) begin
        winner.valid = 1'b1;
        winner.index = 6'(i);
      end
    end
  end

endmodule
`default_nettype wire

//--- design/cip_sticky_flags.sv
// pending flags: set by source, cleared by firmware once source drops
`timescale 1ns/1ps
`default_nettype none
module cip_sticky_flags #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] source,
  input  wire logic [WIDTH-1:0] clearMask,
  output logic      [WIDTH-1:0] pending
);

  logic [WIDTH-1:0] pending_reg;
  logic [WIDTH-1:0] pending_next;

  // a live source keeps or sets its flag, so set wins over clear
  always_comb begin
    pending_next = (pending_reg & ~clearMask) | source;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  assign pending = pending_reg;

endmodule
`default_nettype wire

//--- tb/cip_core_model.sv
// model: processor core taking fast and normal requests
`timescale 1ns/1ps
`default_nettype none
module cip_core_model
  import cip_pkg::*;
(
  input  wire logic       mclk, reset, fastReq, normReq,
  input  wire logic [5:0] fastIdx, normIdx,
  output logic            servedFast,
  output logic      [5:0] servedIndex
);
  // fast line first, then fetch its vector index
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      servedFast  <= 1'b0;
      servedIndex <= CIP_IDX_NONE;
    end else if (fastReq) begin
      servedFast  <= 1'b1;
      servedIndex <= fastIdx;
    end else if (normReq) begin
      servedFast  <= 1'b0;
      servedIndex <= normIdx;
    end
  end
endmodule
`default_nettype wire

//--- tb/cip_unit_chk.sv
// checker: port-level assertions of the central interrupt unit
`timescale 1ns/1ps
`default_nettype none
module cip_unit_chk
  import cip_pkg::*;
(
  input wire logic        mclk, reset, faultMuxEvent, regWrite, regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata, regRdata,
  input wire logic        fastInterruptRequest, normalInterruptRequest, irqOut,
  input wire logic [5:0]  fastVectorIndex, normalVectorIndex
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // read data only in the slot after a read
  rdata_slot_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
  // request lines agree with their indices
  fast_none_a: assert property (fastInterruptRequest == (fastVectorIndex != CIP_IDX_NONE))
    else $error("fast line and index disagree");
  norm_none_a: assert property (normalInterruptRequest == (normalVectorIndex != CIP_IDX_NONE))
    else $error("normal line and index disagree");
  line_split_a: assert property (fastInterruptRequest && normalInterruptRequest |->
    fastVectorIndex != normalVectorIndex)
    else $error("one channel on both lines");
  index_range_a: assert property (fastInterruptRequest |-> fastVectorIndex < 6'h20)
    else $error("fast index out of range");
  mask_quiet_a: assert property (regWrite && regAddr == CIP_OFS_IRQMASK && regWdata[1:0] == 2'h0
    |-> ##2 !irqOut)
    else $error("interrupt with mask cleared");
  index_read_a: assert property (regRead && regAddr == CIP_OFS_FASTIDX && $stable(fastVectorIndex)
    ##1 $stable(fastVectorIndex) |-> regRdata == {26'h0, fastVectorIndex})
    else $error("fast index readback wrong");
  unmapped_read_a: assert property (regRead && regAddr > CIP_OFS_RAW |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  raw_read_a: assert property (regRead && regAddr == CIP_OFS_RAW && $stable(faultMuxEvent)
    ##1 $stable(faultMuxEvent) |-> regRdata[CIP_CH_FAULT_MUX] == faultMuxEvent)
    else $error("raw source readback wrong");
endmodule
bind cip_central_interrupt_unit cip_unit_chk chk (.mclk(mclk), .reset(reset),
  .faultMuxEvent(faultMuxEvent), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .fastInterruptRequest(fastInterruptRequest),
  .normalInterruptRequest(normalInterruptRequest), .irqOut(irqOut),
  .fastVectorIndex(fastVectorIndex), .normalVectorIndex(normalVectorIndex));
`default_nettype wire

//--- tb/tb_central_interrupt_prioritizer.sv
// testbench: central interrupt unit through its register port
`timescale 1ns/1ps
`default_nettype none
module tb_central_interrupt_prioritizer;
  import cip_pkg::*;
  localparam logic [31:0] NAMED = 32'h0300_0FFF;
  logic        mclk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, src = 32'h0, regRdata;
  logic        fastReq, normReq, irqOut, servedFast;
  logic [5:0]  fastIdx, normIdx, servedIndex;
  int          failures = 0, check_count = 0;
  always #4 mclk = ~mclk;
  cip_central_interrupt_unit dut (.mclk(mclk), .reset(reset), .brownoutEvent(src[0]),
    .externalPinEvent(src[1]), .watchdogExpiredEvent(src[2]), .watchdogHalfwayEvent(src[3]),
    .serialErrorEvent(src[4]), .serial0ReceiveEvent(src[5]), .serial0TransmitEvent(src[6]),
    .serial1ReceiveEvent(src[7]), .serial1TransmitEvent(src[8]), .pmbusEvent(src[9]),
    .comparatorSerialSharedEvent(src[10]), .frontEndZeroEvent(src[11]), .conversionDoneEvent(src[24]),
    .faultMuxEvent(src[25]), .otherRequest(src & ~NAMED), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .fastInterruptRequest(fastReq),
    .normalInterruptRequest(normReq), .fastVectorIndex(fastIdx), .normalVectorIndex(normIdx),
    .irqOut(irqOut));
  cip_core_model core (.mclk(mclk), .reset(reset), .fastReq(fastReq), .normReq(normReq),
    .fastIdx(fastIdx), .normIdx(normIdx), .servedFast(servedFast), .servedIndex(servedIndex));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic idle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic drive(input logic [31:0] s);
    @(posedge mclk);
    src <= s;
    idle();
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #50000;
    failures++;
    results();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    idle();
    chk({fastReq, normReq, fastIdx, normIdx}, {2'b00, CIP_IDX_NONE, CIP_IDX_NONE});
    rdc(CIP_OFS_ENABLE, CIP_RST_ENABLE);
    rdc(CIP_OFS_FASTSEL, CIP_RST_FASTSEL);
    wr(CIP_OFS_ENABLE, 32'hFFFF_FFFF);
    wr(CIP_OFS_IRQMASK, 32'h3);
    rdc(CIP_OFS_IRQMASK, 32'h3);
    for (int i = 0; i < 32; i++) begin
      drive(32'h1 << i);
      chk({normReq, normIdx}, {1'b1, 6'(i)});
      drive(32'h0);
      wr(CIP_OFS_PENDING, 32'h1 << i);
      idle();
      chk({normReq, normIdx}, {1'b0, CIP_IDX_NONE});
    end
    rdc(CIP_OFS_STATUS, 32'h2);
    chk(irqOut, 1'b1);
    wr(CIP_OFS_STATUS, 32'h3);
    idle();
    chk(irqOut, 1'b0);
    drive(32'hFFFF_FFFF);
    for (int k = 32; k >= 0; k--) begin
      wr(CIP_OFS_ENABLE, k == 32 ? 32'hFFFF_FFFF : (32'h1 << k) - 32'h1);
      idle();
      chk({26'h0, normIdx}, 32'(k > 0 ? k - 1 : 63));
    end
    wr(CIP_OFS_PENDING, 32'hFFFF_FFFF);
    rdc(CIP_OFS_PENDING, 32'hFFFF_FFFF);
    rdc(CIP_OFS_RAW, 32'hFFFF_FFFF);
    drive(32'h0);
    wr(CIP_OFS_PENDING, 32'hFFFF_FFFF);
    wr(CIP_OFS_ENABLE, 32'hFFFF_FFFF);
    wr(CIP_OFS_FASTSEL, 32'h1 << 30);
    drive(32'h4010_0000);
    chk({fastReq, normReq, fastIdx, normIdx}, {2'b11, 6'h1E, 6'h14});
    chk({servedFast, servedIndex}, {1'b1, 6'h1E});
    rdc(CIP_OFS_FASTIDX, 32'h1E);
    rdc(CIP_OFS_NORMIDX, 32'h14);
    drive(32'h0);
    wr(CIP_OFS_PENDING, 32'hFFFF_FFFF);
    wr(CIP_OFS_ENABLE, 32'h0);
    drive(32'h8);
    drive(32'h0);
    chk(normReq, 1'b0);
    wr(CIP_OFS_ENABLE, 32'h8);
    idle();
    chk({normReq, normIdx}, {1'b1, 6'h03});
    wr(CIP_OFS_IRQMASK, 32'h0);
    idle();
    chk(irqOut, 1'b0);
    wr(8'h24, 32'hFFFF_FFFF);
    rdc(8'h24, 32'h0);
    results();
  end
endmodule
`default_nettype wire
